// ---- agsl_pkg.sv ----
// Package for the gain-swap and level-control register bank: map, layouts, resets, carriers
package agsl_pkg;

    // ************************************************************
    // Register indices
    // ************************************************************
    localparam int AGSL_NREG = 14;
    localparam int AGSL_I_LVL_EN = 0;
    localparam int AGSL_I_RATES = 1;
    localparam int AGSL_I_HOLD = 2;
    localparam int AGSL_I_NOISE = 3;
    localparam int AGSL_I_TGT_LO = 4;
    localparam int AGSL_I_TGT_HI = 5;
    localparam int AGSL_I_GAIN_LIM = 6;
    localparam int AGSL_I_ANA_LIM = 7;
    localparam int AGSL_I_LVL_CLIP = 8;
    localparam int AGSL_I_GS_EN = 9;
    localparam int AGSL_I_GS_TRIG = 10;
    localparam int AGSL_I_GS_ATT = 11;
    localparam int AGSL_I_GS_TMO = 12;
    localparam int AGSL_I_GS_CLIP = 13;

    // ************************************************************
    // Offsets
    // ************************************************************
    localparam logic [7:0] AGSL_OFS_LVL_EN = 8'h30;
    localparam logic [7:0] AGSL_OFS_RATES = 8'h31;
    localparam logic [7:0] AGSL_OFS_HOLD = 8'h32;
    localparam logic [7:0] AGSL_OFS_NOISE = 8'h33;
    localparam logic [7:0] AGSL_OFS_TGT_LO = 8'h34;
    localparam logic [7:0] AGSL_OFS_TGT_HI = 8'h35;
    localparam logic [7:0] AGSL_OFS_GAIN_LIM = 8'h36;
    localparam logic [7:0] AGSL_OFS_ANA_LIM = 8'h37;
    localparam logic [7:0] AGSL_OFS_LVL_CLIP = 8'h38;
    localparam logic [7:0] AGSL_OFS_GS_EN = 8'h3c;
    localparam logic [7:0] AGSL_OFS_GS_TRIG = 8'h3d;
    localparam logic [7:0] AGSL_OFS_GS_ATT = 8'h3e;
    localparam logic [7:0] AGSL_OFS_GS_TMO = 8'h3f;
    localparam logic [7:0] AGSL_OFS_GS_CLIP = 8'h40;

    // ************************************************************
    // Implemented-bit masks (reserved bits are zero)
    // ************************************************************
    localparam logic [7:0] AGSL_MSK_LVL_EN = 8'h5f;
    localparam logic [7:0] AGSL_MSK_RATES = 8'hff;
    localparam logic [7:0] AGSL_MSK_HOLD = 8'h0f;
    localparam logic [7:0] AGSL_MSK_NOISE = 8'h3f;
    localparam logic [7:0] AGSL_MSK_TGT = 8'h3f;
    localparam logic [7:0] AGSL_MSK_GAIN_LIM = 8'hff;
    localparam logic [7:0] AGSL_MSK_ANA_LIM = 8'h77;
    localparam logic [7:0] AGSL_MSK_LVL_CLIP = 8'h83;
    localparam logic [7:0] AGSL_MSK_GS_EN = 8'h03;
    localparam logic [7:0] AGSL_MSK_GS_TRIG = 8'h0f;
    localparam logic [7:0] AGSL_MSK_GS_ATT = 8'h07;
    localparam logic [7:0] AGSL_MSK_GS_TMO = 8'h01;
    localparam logic [7:0] AGSL_MSK_GS_CLIP = 8'h80;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] AGSL_RST_LVL_EN = 8'h00;
    localparam logic [7:0] AGSL_RST_RATES = 8'h00;
    localparam logic [7:0] AGSL_RST_HOLD = 8'h00;
    localparam logic [7:0] AGSL_RST_NOISE = 8'h3f;
    localparam logic [7:0] AGSL_RST_TGT_LO = 8'h3f;
    localparam logic [7:0] AGSL_RST_TGT_HI = 8'h00;
    localparam logic [7:0] AGSL_RST_GAIN_LIM = 8'hff;
    localparam logic [7:0] AGSL_RST_ANA_LIM = 8'h70;
    localparam logic [7:0] AGSL_RST_LVL_CLIP = 8'h00;
    localparam logic [7:0] AGSL_RST_GS_EN = 8'h00;
    localparam logic [7:0] AGSL_RST_GS_TRIG = 8'h09;
    localparam logic [7:0] AGSL_RST_GS_ATT = 8'h00;
    localparam logic [7:0] AGSL_RST_GS_TMO = 8'h00;
    localparam logic [7:0] AGSL_RST_GS_CLIP = 8'h00;

    localparam logic [7:0] AGSL_OFS_TAB [AGSL_NREG] = '{
        AGSL_OFS_LVL_EN, AGSL_OFS_RATES, AGSL_OFS_HOLD, AGSL_OFS_NOISE, AGSL_OFS_TGT_LO,
        AGSL_OFS_TGT_HI, AGSL_OFS_GAIN_LIM, AGSL_OFS_ANA_LIM, AGSL_OFS_LVL_CLIP, AGSL_OFS_GS_EN,
        AGSL_OFS_GS_TRIG, AGSL_OFS_GS_ATT, AGSL_OFS_GS_TMO, AGSL_OFS_GS_CLIP};
    localparam logic [7:0] AGSL_MSK_TAB [AGSL_NREG] = '{
        AGSL_MSK_LVL_EN, AGSL_MSK_RATES, AGSL_MSK_HOLD, AGSL_MSK_NOISE, AGSL_MSK_TGT,
        AGSL_MSK_TGT, AGSL_MSK_GAIN_LIM, AGSL_MSK_ANA_LIM, AGSL_MSK_LVL_CLIP, AGSL_MSK_GS_EN,
        AGSL_MSK_GS_TRIG, AGSL_MSK_GS_ATT, AGSL_MSK_GS_TMO, AGSL_MSK_GS_CLIP};
    localparam logic [7:0] AGSL_RST_TAB [AGSL_NREG] = '{
        AGSL_RST_LVL_EN, AGSL_RST_RATES, AGSL_RST_HOLD, AGSL_RST_NOISE, AGSL_RST_TGT_LO,
        AGSL_RST_TGT_HI, AGSL_RST_GAIN_LIM, AGSL_RST_ANA_LIM, AGSL_RST_LVL_CLIP, AGSL_RST_GS_EN,
        AGSL_RST_GS_TRIG, AGSL_RST_GS_ATT, AGSL_RST_GS_TMO, AGSL_RST_GS_CLIP};

    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int AGSL_ALC_EN_LSB = 0;
    localparam int AGSL_HYB_CH1_BIT = 4;
    localparam int AGSL_HYB_CH2_BIT = 6;
    localparam int AGSL_RELEASE_LSB = 4;
    localparam int AGSL_ATTACK_LSB = 0;
    localparam int AGSL_GS_EN_LSB = 0;
    localparam int AGSL_TRIG_LSB = 0;
    localparam int AGSL_ATT_LSB = 0;
    localparam int AGSL_TMO_BIT = 0;
    localparam int AGSL_GS_CLIP_BIT = 7;
    localparam logic [2:0] AGSL_ATT_RESERVED = 3'h7;
    localparam logic [3:0] AGSL_RELEASE_SAT = 4'ha;
    localparam logic [3:0] AGSL_ATTACK_SAT = 4'hc;
    localparam logic [6:0] AGSL_STEP_DB = 7'h06;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } agsl_req_t;

    typedef struct packed {
        logic [1:0] gs_en;
        logic [3:0] gs_trigger;
        logic [6:0] gs_trigger_db;
        logic [2:0] gs_att_max;
        logic [6:0] gs_att_db;
        logic gs_timeout_en;
        logic gs_clip_en;
        logic [3:0] alc_en;
        logic [1:0] hybrid_en;
        logic [3:0] release_eff;
        logic [3:0] attack_eff;
    } agsl_cfg_t;

    typedef struct packed {
        logic [3:0] hold;
        logic [5:0] noise;
        logic [5:0] target_low;
        logic [5:0] target_high;
        logic [7:0] gain_limits;
        logic [7:0] analog_gain_limits;
        logic [7:0] clip_guard;
    } agsl_aux_t;

endpackage

// ---- agsl_field.sv ----
// One masked 8-bit control register with reset value
`timescale 1ns/10ps
module agsl_field
    import agsl_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RST = 8'h00
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Write side
    input wire logic wr,
    input wire logic [7:0] wdata,
    // Stored value
    output logic [7:0] q
);
    logic [7:0] q_q;
    logic [7:0] q_d;

    // Reserved positions never store, so they read back zero
    assign q_d = wr ? (wdata & MASK) : q_q;
    assign q = q_q;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q_q <= RST & MASK;
        end else if (ce) begin
            q_q <= q_d;
        end
    end
endmodule

// ---- agsl_regs.sv ----
// Gain-swap and level-control register bank with decoded control outputs
`timescale 1ns/10ps
module agsl_regs
    import agsl_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Register access from the control interface
    input wire agsl_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic wr_refused,
    // Decoded controls
    output agsl_cfg_t cfg,
    output agsl_aux_t aux
);

    // ************************************************************
    // Address decode
    // ************************************************************
    logic [7:0] reg_q [AGSL_NREG];
    logic [AGSL_NREG-1:0] hit;
    logic [AGSL_NREG-1:0] wr_hit;
    logic [7:0] rd_term [AGSL_NREG];
    logic [7:0] rd_mux;
    logic att_bad;

    // Reserved attenuation code is refused, keeping the last legal setting
    assign att_bad = (req.wdata[AGSL_ATT_LSB +: 3] == AGSL_ATT_RESERVED);

    genvar gi;
    generate
        for (gi = 0; gi < AGSL_NREG; gi = gi + 1) begin : g_reg
            assign hit[gi] = (req.addr == AGSL_OFS_TAB[gi]);
            assign wr_hit[gi] = req.wr && hit[gi] && !((gi == AGSL_I_GS_ATT) && att_bad);
            assign rd_term[gi] = hit[gi] ? reg_q[gi] : 8'h00;
            agsl_field #(
                .MASK(AGSL_MSK_TAB[gi]),
                .RST(AGSL_RST_TAB[gi])
            ) u_field (
                .clock(clock),
                .rst_b(rst_b),
                .ce(ce),
                .wr(wr_hit[gi]),
                .wdata(req.wdata),
                .q(reg_q[gi])
            );
        end
    endgenerate

    // Unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < AGSL_NREG; i++) begin
            rd_mux = rd_mux | rd_term[i];
        end
    end

    // ************************************************************
    // Field extraction
    // ************************************************************
    logic [7:0] lvl_en_r;
    logic [7:0] rates_r;
    logic [3:0] trig_code;
    logic [2:0] att_code;
    logic [3:0] rel_code;
    logic [3:0] atk_code;
    logic [3:0] rel_eff;
    logic [3:0] atk_eff;
    logic [6:0] trig_db;
    logic [6:0] att_db;
    agsl_cfg_t cfg_d;
    agsl_aux_t aux_d;

    assign lvl_en_r = reg_q[AGSL_I_LVL_EN];
    assign rates_r = reg_q[AGSL_I_RATES];
    assign trig_code = reg_q[AGSL_I_GS_TRIG][AGSL_TRIG_LSB +: 4];
    assign att_code = reg_q[AGSL_I_GS_ATT][AGSL_ATT_LSB +: 3];
    assign rel_code = rates_r[AGSL_RELEASE_LSB +: 4];
    assign atk_code = rates_r[AGSL_ATTACK_LSB +: 4];

    // Magnitudes in dB; trigger is a level below full scale
    assign trig_db = 7'({3'h0, trig_code} * AGSL_STEP_DB);
    assign att_db = 7'({4'h0, att_code} * AGSL_STEP_DB);

    // Top codes share one rate, so the downstream table needs no extra entries
    assign rel_eff = (rel_code > AGSL_RELEASE_SAT) ? AGSL_RELEASE_SAT : rel_code;
    assign atk_eff = (atk_code > AGSL_ATTACK_SAT) ? AGSL_ATTACK_SAT : atk_code;

    assign cfg_d.gs_en = reg_q[AGSL_I_GS_EN][AGSL_GS_EN_LSB +: 2];
    assign cfg_d.gs_trigger = trig_code;
    assign cfg_d.gs_trigger_db = trig_db;
    assign cfg_d.gs_att_max = att_code;
    assign cfg_d.gs_att_db = att_db;
    assign cfg_d.gs_timeout_en = reg_q[AGSL_I_GS_TMO][AGSL_TMO_BIT];
    assign cfg_d.gs_clip_en = reg_q[AGSL_I_GS_CLIP][AGSL_GS_CLIP_BIT];
    assign cfg_d.alc_en = lvl_en_r[AGSL_ALC_EN_LSB +: 4];
    assign cfg_d.hybrid_en = {lvl_en_r[AGSL_HYB_CH2_BIT], lvl_en_r[AGSL_HYB_CH1_BIT]};
    assign cfg_d.release_eff = rel_eff;
    assign cfg_d.attack_eff = atk_eff;

    assign aux_d.hold = reg_q[AGSL_I_HOLD][3:0];
    assign aux_d.noise = reg_q[AGSL_I_NOISE][5:0];
    assign aux_d.target_low = reg_q[AGSL_I_TGT_LO][5:0];
    assign aux_d.target_high = reg_q[AGSL_I_TGT_HI][5:0];
    assign aux_d.gain_limits = reg_q[AGSL_I_GAIN_LIM];
    assign aux_d.analog_gain_limits = reg_q[AGSL_I_ANA_LIM];
    assign aux_d.clip_guard = reg_q[AGSL_I_LVL_CLIP];

    // ************************************************************
    // Output flops
    // ************************************************************
    agsl_cfg_t cfg_q;
    agsl_aux_t aux_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic wr_refused_q;
    logic refuse_d;

    assign refuse_d = req.wr && hit[AGSL_I_GS_ATT] && att_bad;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cfg_q <= '0;
            aux_q <= '0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            wr_refused_q <= 1'b0;
        end else if (ce) begin
            cfg_q <= cfg_d;
            aux_q <= aux_d;
            rdata_q <= req.rd ? rd_mux : 8'h00;
            rvalid_q <= req.rd;
            wr_refused_q <= refuse_d;
        end
    end

    assign cfg = cfg_q;
    assign aux = aux_q;
    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign wr_refused = wr_refused_q;

endmodule

// ---- agsl_regs_properties.sv ----
// Concurrent checks on the gain-swap and level-control register bank ports
`timescale 1ns/10ps
module agsl_regs_properties
    import agsl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Register port
    input wire agsl_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic wr_refused,
    // Decoded controls
    input wire agsl_cfg_t cfg,
    input wire agsl_aux_t aux
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic wr_go = ce && req.wr;
    a_trigger_write: assert property (wr_go && req.addr == 8'h3d ##1 ce |=>
        cfg.gs_trigger == $past(req.wdata[3:0], 2)) else $error("trigger field not mirrored");
    a_trigger_scale: assert property (cfg.gs_trigger_db == {3'h0, cfg.gs_trigger} * 7'h06)
        else $error("trigger level scale wrong");
    a_atten_scale: assert property (cfg.gs_att_max != 3'h7 &&
        cfg.gs_att_db == {4'h0, cfg.gs_att_max} * 7'h06) else $error("attenuation scale wrong");
    a_atten_refused: assert property (wr_go && req.addr == 8'h3e && req.wdata[2:0] == 3'h7 |=> wr_refused)
        else $error("reserved attenuation not refused");
    a_timeout_write: assert property (wr_go && req.addr == 8'h3f ##1 ce |=>
        cfg.gs_timeout_en == $past(req.wdata[0], 2)) else $error("timeout enable not mirrored");
    a_clip_write: assert property (wr_go && req.addr == 8'h40 ##1 ce |=>
        cfg.gs_clip_en == $past(req.wdata[7], 2)) else $error("clip guard not mirrored");
    a_level_write: assert property (wr_go && req.addr == 8'h30 ##1 ce |=> cfg.alc_en == $past(req.wdata[3:0], 2)
        && cfg.hybrid_en == {$past(req.wdata[6], 2), $past(req.wdata[4], 2)}) else $error("level enables wrong");
    a_reset_off: assert property ($rose(rst_b) |=> cfg.alc_en == 4'h0 && cfg.hybrid_en == 2'h0
        && cfg.gs_en == 2'h0 && cfg.gs_trigger == 4'h9) else $error("controls not at reset state");
    a_rate_clamp: assert property (cfg.release_eff <= 4'ha && cfg.attack_eff <= 4'hc)
        else $error("rate code not clamped");
    a_read_answer: assert property (ce && req.rd |=> rvalid) else $error("read not answered");
    a_read_idle: assert property (ce && !req.rd |=> !rvalid && rdata == 8'h00)
        else $error("read data outside a read");
    c_refusal: cover property (wr_go && req.addr == 8'h3e && req.wdata[2:0] == 3'h7);
    c_trigger: cover property (wr_go && req.addr == 8'h3d);
    c_read: cover property (ce && req.rd);
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the gain-swap and level-control register bank
`timescale 1ns/10ps
module tb_top;
    import agsl_pkg::*;
    logic clock;
    logic rst_b;
    logic ce;
    agsl_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic wr_refused;
    agsl_cfg_t cfg;
    agsl_aux_t aux;
    int err_total;
    int num_checks;
    agsl_regs uut (.clock(clock), .rst_b(rst_b), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
        .wr_refused(wr_refused), .cfg(cfg), .aux(aux));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, 1'b0, a, d);
        put(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        put(1'b0, 1'b1, a, 8'h00);
        put(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
        v = rdata;
        chk("read valid", {7'h00, rvalid}, 8'h01);
    endtask
    task automatic settle;
        @(posedge clock);
        #1;
    endtask
    task automatic check_resets;
        logic [7:0] v;
        for (int i = 0; i < AGSL_NREG; i++) begin
            rreg(AGSL_OFS_TAB[i], v);
            chk("reset value", v, AGSL_RST_TAB[i]);
        end
    endtask
    task automatic check_aux(input logic ones);
        chk("hold", {4'h0, aux.hold}, ones ? AGSL_MSK_HOLD : AGSL_RST_HOLD);
        chk("noise", {2'h0, aux.noise}, ones ? AGSL_MSK_NOISE : AGSL_RST_NOISE);
        chk("target low", {2'h0, aux.target_low}, ones ? AGSL_MSK_TGT : AGSL_RST_TGT_LO);
        chk("target high", {2'h0, aux.target_high}, ones ? AGSL_MSK_TGT : AGSL_RST_TGT_HI);
        chk("gain limits", aux.gain_limits, ones ? AGSL_MSK_GAIN_LIM : AGSL_RST_GAIN_LIM);
        chk("analog limits", aux.analog_gain_limits, ones ? AGSL_MSK_ANA_LIM : AGSL_RST_ANA_LIM);
        chk("level clip", aux.clip_guard, ones ? AGSL_MSK_LVL_CLIP : AGSL_RST_LVL_CLIP);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        logic [7:0] v;
        logic [7:0] e;
        err_total = 0;
        num_checks = 0;
        ce = 1'b1;
        rst_b = 1'b0;
        req = '0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        check_resets();
        chk("trigger db", {1'b0, cfg.gs_trigger_db}, 8'h36);
        check_aux(1'b0);
        // Reserved bits drop; all-ones attenuation is code 111 and must be refused
        for (int i = 0; i < AGSL_NREG; i++) begin
            wreg(AGSL_OFS_TAB[i], 8'hff);
            rreg(AGSL_OFS_TAB[i], v);
            chk("masked readback", v, (i == AGSL_I_GS_ATT) ? 8'h00 : AGSL_MSK_TAB[i]);
        end
        chk("enables", {cfg.alc_en, cfg.hybrid_en, cfg.gs_en}, 8'hff);
        chk("rates", {cfg.release_eff, cfg.attack_eff}, 8'hac);
        chk("guards", {6'h00, cfg.gs_timeout_en, cfg.gs_clip_en}, 8'h03);
        check_aux(1'b1);
        // Clearing must turn both guards off again
        wreg(AGSL_OFS_GS_TMO, 8'h00);
        wreg(AGSL_OFS_GS_CLIP, 8'h00);
        settle();
        chk("guards clear", {6'h00, cfg.gs_timeout_en, cfg.gs_clip_en}, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wreg(8'h3d, 8'(c));
            wreg(8'h31, {4'(c), 4'(c)});
            settle();
            chk("trigger db", {1'b0, cfg.gs_trigger_db}, 8'(c * 6));
            chk("trigger code", {4'h0, cfg.gs_trigger}, 8'(c));
            chk("release", {4'h0, cfg.release_eff}, 8'((c > 10) ? 10 : c));
            chk("attack", {4'h0, cfg.attack_eff}, 8'((c > 12) ? 12 : c));
        end
        for (int c = 0; c < 8; c++) begin
            wreg(8'h3e, 8'(c));
            chk("refusal", {7'h00, wr_refused}, 8'(c == 7));
            settle();
            chk("atten db", {1'b0, cfg.gs_att_db}, 8'((c == 7) ? 36 : c * 6));
            chk("atten code", {5'h00, cfg.gs_att_max}, 8'((c == 7) ? 6 : c));
        end
        for (int b = 0; b < 8; b++) begin
            e = 8'h01 << b;
            wreg(8'h30, e);
            settle();
            chk("level enable", {cfg.alc_en, 2'h0, cfg.hybrid_en}, {e[3:0], 2'h0, e[6], e[4]});
        end
        wreg(8'h39, 8'h5a);
        rreg(8'h39, v);
        chk("unmapped", v, 8'h00);
        // Frozen enable must swallow the write
        @(posedge clock);
        ce <= 1'b0;
        wreg(8'h3c, 8'h00);
        @(posedge clock);
        ce <= 1'b1;
        rreg(8'h3c, v);
        chk("frozen write", v, 8'h03);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        check_resets();
        check_aux(1'b0);
        chk("guards reset", {6'h00, cfg.gs_timeout_en, cfg.gs_clip_en}, 8'h00);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        conclude();
    end
endmodule

bind agsl_regs agsl_regs_properties chk_i (.clock(clock), .rst_b(rst_b), .ce(ce), .req(req), .rdata(rdata),
    .rvalid(rvalid), .wr_refused(wr_refused), .cfg(cfg), .aux(aux));
